// ==== common/pmwc_consts.svh ====
// offsets, field positions and counts for the power mode and wake control block
`ifndef PMWC_CONSTS_SVH
`define PMWC_CONSTS_SVH
`define PMWC_ADDR_W           8
`define PMWC_OFS_PWR_CTRL     8'h87
`define PMWC_OFS_WAKE_CFG     8'hB5
`define PMWC_PWR_CTRL_RESET   8'h00
`define PMWC_WAKE_EN_RESET    4'h0
`define PMWC_BIT_SLEEP        7
`define PMWC_BIT_SUSPEND      6
`define PMWC_BIT_CLEAR        5
`define PMWC_BIT_RST_FLAG     4
`define PMWC_BIT_STOP         1
`define PMWC_BIT_IDLE         0
`define PMWC_GPF_HI           7
`define PMWC_GPF_LO           2
`define PMWC_SRC_HI           3
`define PMWC_WAKE_HIDE_CYC    2'h2
`endif

// ==== common/pmwc_pkg.sv ====
// types for the power mode and wake control block
`default_nettype none
package pmwc_pkg;
  typedef enum logic [1:0] {
    PMWC_RUN,
    PMWC_SUSPEND,
    PMWC_SLEEP
  } pmwc_mode_e;
endpackage : pmwc_pkg
`default_nettype wire

// ==== rtl/pmwc_power_mode_wake_control.sv ====
// power mode select, wake-up source enables and wake-up flags
//
// Function
// RQ1: writing 1 to wake config bit 7 enters sleep mode
// RQ2: writing 1 to wake config bit 6 enters suspend mode; the code enters sleep instead when bit 7 is also written 1
// RQ3: writing 1 to wake config bit 5 clears all wake flags at once
// RQ4: bit 4 reads the reset pin falling edge flag
// RQ5: bit 3 enables oscillator fail wake; reads oscillator fail flag
// RQ6: bit 2 enables alarm wake; reads alarm flag
// RQ7: bit 1 enables port match wake; reads port match flag
// RQ8: bit 0 enables comparator rise wake; reads comparator flag
// RQ9: software avoids read-modify-write; reads give flags, not enables
// RQ10: software re-enables wake sources with every sleep or suspend write
// RQ11: any set flag blocks suspend and sleep, keeps low power oscillator on
// RQ12: software clears sources and flags after reset and after wake
// RQ13: power control bits 7:2 are six read/write general flags
// RQ14: writing 1 to power control bit 1 enters stop mode
// RQ15: writing 1 to power control bit 0 enters idle mode; the code raises no IDLE_REQ when bit 1 is also written 1
// RQ16: flags update on their event regardless of enable, also after wake
// RQ17: flags read 0 for two clocks after wake from suspend
// RQ18: reset pin falling edge always wakes from sleep
// RQ19: software writes enables in the same write as the mode select
// RQ20: write-only select and clear bits read as 0
// RQ21: enabled event or reset pin edge ends suspend or sleep at once
`timescale 1ns/1ps
`default_nettype none
`include "pmwc_consts.svh"

module pmwc_power_mode_wake_control
  import pmwc_pkg::*;
#(
  parameter int SRC_N = 4
) (
  input  wire logic                      SYS_CLK,
  input  wire logic                      RESETN,
  input  wire logic [`PMWC_ADDR_W-1:0]   ADDR,
  input  wire logic [7:0]                WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  output logic      [7:0]                RDATA,
  input  wire logic                      RST_PIN_N,
  input  wire logic                      RTC_OSC_FAIL,
  input  wire logic                      RTC_ALARM,
  input  wire logic                      PORT_MATCH,
  input  wire logic                      COMPARATOR_OUT,
  output logic                           SLEEP_MODE,
  output logic                           SUSPEND_MODE,
  output logic                           STOP_REQ,
  output logic                           IDLE_REQ,
  output logic                           LP_OSC_KEEP_ON
);

  ////////////////////////////////////////////////////////////////////////////
  // decode and event detection
  logic                 wr_cfg;
  logic                 wr_pwr;
  logic                 rst_pin_q;
  logic                 cmp_q;
  logic                 rst_fall;
  logic [SRC_N-1:0]     src_evt;
  logic [SRC_N-1:0]     wake_en_q;
  logic [SRC_N-1:0]     src_flag_q;
  logic                 rst_flag_q;
  logic                 any_flag;
  logic                 wake_evt;
  logic [5:0]           gpf_q;
  logic [1:0]           hide_q;
  pmwc_mode_e           mode_q;

  assign wr_cfg   = WR && (ADDR == `PMWC_OFS_WAKE_CFG);
  assign wr_pwr   = WR && (ADDR == `PMWC_OFS_PWR_CTRL);
  assign rst_fall = rst_pin_q && !RST_PIN_N;
  // comparator counts only on its rising edge; other sources are levels
  assign src_evt  = {RTC_OSC_FAIL, RTC_ALARM, PORT_MATCH, COMPARATOR_OUT && !cmp_q};
  assign any_flag = rst_flag_q || (|src_flag_q);
  assign wake_evt = rst_fall || (|(src_evt & wake_en_q)); // RQ18 RQ21

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_pin_q <= 1'b1;
      cmp_q     <= 1'b0;
    end else begin
      rst_pin_q <= RST_PIN_N;
      cmp_q     <= COMPARATOR_OUT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake source enables
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wake_en_q <= `PMWC_WAKE_EN_RESET;
    end else if (wr_cfg) begin
      wake_en_q <= WDATA[`PMWC_SRC_HI:0]; // RQ5 RQ6 RQ7 RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake flags: set wins over clear, set whether enabled or not
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      src_flag_q <= '0;
      rst_flag_q <= 1'b0;
    end else begin
      if (wr_cfg && WDATA[`PMWC_BIT_CLEAR]) begin
        src_flag_q <= src_evt; // RQ3 RQ16
        rst_flag_q <= rst_fall; // RQ3 RQ4
      end else begin
        src_flag_q <= src_flag_q | src_evt; // RQ16
        rst_flag_q <= rst_flag_q | rst_fall; // RQ4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low power mode state
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_q <= PMWC_RUN;
    end else begin
      unique case (mode_q)
        PMWC_RUN: begin
          // refused while a flag is set
          if (wr_cfg && !any_flag) begin // RQ11
            if (WDATA[`PMWC_BIT_SLEEP]) begin
              mode_q <= PMWC_SLEEP; // RQ1
            end else if (WDATA[`PMWC_BIT_SUSPEND]) begin
              mode_q <= PMWC_SUSPEND; // RQ2
            end
          end
        end
        PMWC_SUSPEND,
        PMWC_SLEEP: begin
          if (wake_evt) begin
            mode_q <= PMWC_RUN; // RQ21
          end
        end
      endcase
    end
  end

  // flags hidden for two clocks after leaving suspend
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      hide_q <= 2'h0;
    end else if (mode_q == PMWC_SUSPEND && wake_evt) begin
      hide_q <= `PMWC_WAKE_HIDE_CYC; // RQ17
    end else if (hide_q != 2'h0) begin
      hide_q <= hide_q - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power control: general flags, stop and idle pulses
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gpf_q <= 6'(`PMWC_PWR_CTRL_RESET >> `PMWC_GPF_LO);
    end else if (wr_pwr) begin
      gpf_q <= WDATA[`PMWC_GPF_HI:`PMWC_GPF_LO]; // RQ13
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      STOP_REQ <= 1'b0;
      IDLE_REQ <= 1'b0;
    end else begin
      STOP_REQ <= wr_pwr && WDATA[`PMWC_BIT_STOP]; // RQ14
      IDLE_REQ <= wr_pwr && WDATA[`PMWC_BIT_IDLE] && !WDATA[`PMWC_BIT_STOP]; // RQ15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and read port
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SLEEP_MODE     <= 1'b0;
      SUSPEND_MODE   <= 1'b0;
      LP_OSC_KEEP_ON <= 1'b1;
    end else begin
      SLEEP_MODE     <= (mode_q == PMWC_SLEEP);
      SUSPEND_MODE   <= (mode_q == PMWC_SUSPEND);
      LP_OSC_KEEP_ON <= (mode_q == PMWC_RUN) || any_flag; // RQ11
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else if (RD && ADDR == `PMWC_OFS_WAKE_CFG) begin
      // select and clear bits read 0; enables never read back
      if (hide_q != 2'h0) begin
        RDATA <= 8'h00; // RQ17
      end else begin
        RDATA <= {3'h0, rst_flag_q, src_flag_q}; // RQ20 RQ9
      end
    end else if (RD && ADDR == `PMWC_OFS_PWR_CTRL) begin
      RDATA <= {gpf_q, 2'h0}; // RQ13 RQ20
    end else begin
      RDATA <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_sleep_entry;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (mode_q == PMWC_RUN && wr_cfg && WDATA[`PMWC_BIT_SLEEP] && !any_flag)
      |=> (mode_q == PMWC_SLEEP) ##1 SLEEP_MODE;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered"); // RQ1

  property p_suspend_entry;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (mode_q == PMWC_RUN && wr_cfg && !WDATA[`PMWC_BIT_SLEEP]
       && WDATA[`PMWC_BIT_SUSPEND] && !any_flag) |-> ##2 SUSPEND_MODE;
  endproperty
  a_suspend_entry: assert property (p_suspend_entry) else $error("suspend not entered"); // RQ2

  property p_clear_all;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (wr_cfg && WDATA[`PMWC_BIT_CLEAR] && !rst_fall && src_evt == '0) |=> !any_flag;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("flags not cleared"); // RQ3

  property p_rst_flag;
    @(posedge SYS_CLK) disable iff (!RESETN)
      rst_fall |=> rst_flag_q;
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("reset pin flag missed"); // RQ4

  property p_refuse;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (mode_q == PMWC_RUN && any_flag) |=> (mode_q == PMWC_RUN) ##1 LP_OSC_KEEP_ON;
  endproperty
  a_refuse: assert property (p_refuse) else $error("low power entered with flag set"); // RQ11

  property p_gpf;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (wr_pwr ##1 (RD && ADDR == `PMWC_OFS_PWR_CTRL && !wr_pwr))
      |=> RDATA == {$past(WDATA, 2) & 8'hFC};
  endproperty
  a_gpf: assert property (p_gpf) else $error("general flag readback wrong"); // RQ13

  property p_stop;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (wr_pwr && WDATA[`PMWC_BIT_STOP]) |=> STOP_REQ ##1 !STOP_REQ || $past(wr_pwr);
  endproperty
  a_stop: assert property (p_stop) else $error("stop request missing"); // RQ14

  property p_idle;
    @(posedge SYS_CLK) disable iff (!RESETN)
      IDLE_REQ |-> $past(wr_pwr && WDATA[`PMWC_BIT_IDLE]);
  endproperty
  a_idle: assert property (p_idle) else $error("idle without request"); // RQ15

  property p_hide;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (mode_q == PMWC_SUSPEND && wake_evt ##1 (RD && ADDR == `PMWC_OFS_WAKE_CFG))
      |=> RDATA == 8'h00;
  endproperty
  a_hide: assert property (p_hide) else $error("flags visible too early"); // RQ17

  property p_wake;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (mode_q != PMWC_RUN && wake_evt) |=> mode_q == PMWC_RUN ##1 !SLEEP_MODE && !SUSPEND_MODE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on event"); // RQ21 RQ18

  property p_sleep_wins;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (mode_q == PMWC_RUN && wr_cfg && WDATA[`PMWC_BIT_SLEEP] && WDATA[`PMWC_BIT_SUSPEND]
       && !any_flag) |=> (mode_q == PMWC_SLEEP);
  endproperty
  a_sleep_wins: assert property (p_sleep_wins) else $error("sleep not preferred"); // RQ1

  property p_lp_osc;
    @(posedge SYS_CLK) disable iff (!RESETN)
      any_flag |=> LP_OSC_KEEP_ON;
  endproperty
  a_lp_osc: assert property (p_lp_osc) else $error("oscillator released with flag set"); // RQ11

  property p_flag_set;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (src_evt != '0) |=> ((src_flag_q & $past(src_evt)) == $past(src_evt));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("wake flag not set on event"); // RQ16

  property p_en_write;
    @(posedge SYS_CLK) disable iff (!RESETN)
      wr_cfg |=> (wake_en_q == $past(WDATA[`PMWC_SRC_HI:0]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("wake enables not written"); // RQ5 RQ6 RQ7 RQ8

  property p_hide_second;
    @(posedge SYS_CLK) disable iff (!RESETN)
      ((mode_q == PMWC_SUSPEND && wake_evt) ##2 (RD && ADDR == `PMWC_OFS_WAKE_CFG)) |=> RDATA == 8'h00;
  endproperty
  a_hide_second: assert property (p_hide_second) else $error("flags visible in second clock"); // RQ17

  property p_cfg_wo_zero;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (RD && ADDR == `PMWC_OFS_WAKE_CFG) |=> (RDATA[`PMWC_BIT_SLEEP:`PMWC_BIT_CLEAR] == 3'h0);
  endproperty
  a_cfg_wo_zero: assert property (p_cfg_wo_zero) else $error("wake command bits read back"); // RQ20

  property p_pwr_wo_zero;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (RD && ADDR == `PMWC_OFS_PWR_CTRL) |=> (RDATA[`PMWC_BIT_STOP:`PMWC_BIT_IDLE] == 2'h0);
  endproperty
  a_pwr_wo_zero: assert property (p_pwr_wo_zero) else $error("stop or idle bit read back"); // RQ20

  property p_rst_wake;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (mode_q == PMWC_SLEEP && rst_fall) |=> (mode_q == PMWC_RUN);
  endproperty
  a_rst_wake: assert property (p_rst_wake) else $error("reset pin edge did not wake"); // RQ18

  property p_stay_low;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (mode_q != PMWC_RUN && !wake_evt) |=> (mode_q == $past(mode_q));
  endproperty
  a_stay_low: assert property (p_stay_low) else $error("low power left without event"); // RQ21

  property p_gpf_hold;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !wr_pwr |=> $stable(gpf_q);
  endproperty
  a_gpf_hold: assert property (p_gpf_hold) else $error("general flags changed without write"); // RQ13

  property p_idle_pulse;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (wr_pwr && WDATA[`PMWC_BIT_IDLE] && !WDATA[`PMWC_BIT_STOP]) |=> IDLE_REQ;
  endproperty
  a_idle_pulse: assert property (p_idle_pulse) else $error("idle request missing"); // RQ15

  property p_stop_cause;
    @(posedge SYS_CLK) disable iff (!RESETN)
      STOP_REQ |-> $past(wr_pwr && WDATA[`PMWC_BIT_STOP]);
  endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("stop without request"); // RQ14

  c_sleep_wake: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    mode_q == PMWC_SLEEP ##[1:50] rst_fall);
  c_suspend_wake: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    mode_q == PMWC_SUSPEND && wake_evt);
  c_refused: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_cfg && WDATA[`PMWC_BIT_SLEEP] && any_flag);
  c_clear_race: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_cfg && WDATA[`PMWC_BIT_CLEAR] && rst_fall);

endmodule : pmwc_power_mode_wake_control
`default_nettype wire

// ==== verification/pmwc_power_mode_wake_control_test.sv ====
// self-checking testbench for the power mode and wake control block
`timescale 1ns/1ps
`default_nettype none
`include "pmwc_consts.svh"

module pmwc_power_mode_wake_control_test
  import pmwc_pkg::*;
;
  localparam logic [7:0] PWR = `PMWC_OFS_PWR_CTRL;
  localparam logic [7:0] WKC = `PMWC_OFS_WAKE_CFG;

  logic       sys_clk   = 1'b0;
  logic       resetn    = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic       wr_s      = 1'b0;
  logic       rd_s      = 1'b0;
  logic       rst_pin_n = 1'b1;
  logic [2:0] lvl       = 3'h0;
  logic       comp      = 1'b0;
  logic [7:0] rdata;
  logic       sleep;
  logic       suspend;
  logic       stop_req;
  logic       idle_req;
  logic       lp_osc;
  int         failures     = 0;
  int         total_checks = 0;

  pmwc_power_mode_wake_control pmwc_power_mode_wake_control_inst (
    .SYS_CLK        (sys_clk),
    .RESETN         (resetn),
    .ADDR           (addr),
    .WDATA          (wdata),
    .WR             (wr_s),
    .RD             (rd_s),
    .RDATA          (rdata),
    .RST_PIN_N      (rst_pin_n),
    .RTC_OSC_FAIL   (lvl[2]),
    .RTC_ALARM      (lvl[1]),
    .PORT_MATCH     (lvl[0]),
    .COMPARATOR_OUT (comp),
    .SLEEP_MODE     (sleep),
    .SUSPEND_MODE   (suspend),
    .STOP_REQ       (stop_req),
    .IDLE_REQ       (idle_req),
    .LP_OSC_KEEP_ON (lp_osc)
  );

  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // every task that waits returns 1 ns after an edge, so drivers never collide in one step
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // strobes drop at the sampling edge, so a following call raises them 1 ns later
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge sys_clk);
    wr_s  <= 1'b0;
    #1;
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask : rdchk

  // one-cycle event on a level source; index 2 fail, 1 alarm, 0 port match
  task ev(input int i);
    lvl <= 3'h1 << i;
    @(posedge sys_clk);
    lvl <= 3'h0;
    #1;
  endtask : ev

  // counts request pulses over three cycles, so the exact cycle is not assumed
  task pulses(input logic [7:0] es, input logic [7:0] ei);
    logic [7:0] ns;
    logic [7:0] ni;
    ns = 8'h00;
    ni = 8'h00;
    repeat (3) begin
      ns = ns + {7'h00, stop_req};
      ni = ni + {7'h00, idle_req};
      tick(1);
    end
    chk("stop_req pulses", ns, es);
    chk("idle_req pulses", ni, ei);
  endtask : pulses

  task mode(input logic [7:0] exp);
    chk("sleep and suspend", {6'h00, sleep, suspend}, exp);
  endtask : mode

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] exp;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    tick(1);
    rdchk(PWR, `PMWC_PWR_CTRL_RESET, "power_control reset");
    rdchk(WKC, 8'h00, "wake flags reset");
    wr(WKC, 8'h20);
    rdchk(8'h00, 8'h00, "unmapped read");
    chk("lp osc in run", {7'h00, lp_osc}, 8'h01);
    $display("test reset values done");

    wr(PWR, 8'hFC);
    rdchk(PWR, 8'hFC, "general flags");
    wr(PWR, 8'hAB);
    pulses(8'h01, 8'h00);
    rdchk(PWR, 8'hA8, "select bits read 0");
    wr(PWR, 8'h55);
    pulses(8'h00, 8'h01);
    wr(8'h86, 8'hFF);
    rdchk(PWR, 8'h54, "general flags kept");
    $display("test power control done");

    exp = 8'h00;
    for (int i = 2; i >= 0; i--) begin
      ev(i);
      exp = exp | (8'h02 << i);
      rdchk(WKC, exp, "level flag without enable");
    end
    comp <= 1'b1;
    tick(1);
    rdchk(WKC, 8'h0F, "comparator flag");
    comp      <= 1'b0;
    rst_pin_n <= 1'b0;
    tick(1);
    rst_pin_n <= 1'b1;
    rdchk(WKC, 8'h1F, "reset pin flag");
    for (int k = 0; k < 2; k++) begin
      wr(WKC, 8'h40 << k);
      tick(2);
      mode(8'h00);
      chk("lp osc with flags", {7'h00, lp_osc}, 8'h01);
    end
    wr(WKC, 8'h20);
    rdchk(WKC, 8'h00, "clear all flags");
    $display("test flags done");

    wr(WKC, 8'h81);
    tick(2);
    mode(8'h02);
    chk("lp osc in sleep", {7'h00, lp_osc}, 8'h00);
    rdchk(WKC, 8'h00, "mode bits read 0");
    ev(0);
    tick(2);
    mode(8'h02);
    comp <= 1'b1;
    tick(1);
    comp <= 1'b0;
    tick(2);
    mode(8'h00);
    rdchk(WKC, 8'h03, "comparator wake flag");
    wr(WKC, 8'h20);
    $display("test sleep wake done");

    wr(WKC, 8'h44);
    tick(2);
    mode(8'h01);
    ev(1);
    rdchk(WKC, 8'h00, "flags hidden after wake");
    rdchk(WKC, 8'h00, "flags hidden second clock");
    mode(8'h00);
    rdchk(WKC, 8'h04, "alarm wake flag");
    wr(WKC, 8'h20);
    $display("test suspend wake done");

    wr(WKC, 8'hC0);
    tick(2);
    mode(8'h02);
    rst_pin_n <= 1'b0;
    tick(3);
    mode(8'h00);
    rdchk(WKC, 8'h10, "reset pin wake flag");
    rst_pin_n <= 1'b1;
    $display("test reset pin wake done");
    close_out();
  end
endmodule : pmwc_power_mode_wake_control_test

`default_nettype wire
